/* File: design/pio_map.vh */
`ifndef PIO_MAP_VH
`define PIO_MAP_VH

// ------------------------------------------------------------
// register address: kind in addr[5:2], port (0..2) in addr[1:0]
// ------------------------------------------------------------
`define PIO_ADDR_W        6
`define PIO_KIND_LATCH    4'h0
`define PIO_KIND_ADSEL    4'h1
`define PIO_KIND_OTYPE    4'h2
`define PIO_KIND_DRIVE    4'h3
`define PIO_KIND_SKIP     4'h4
`define PIO_KIND_MMASK    4'h5
`define PIO_KIND_MVAL     4'h6
`define PIO_KIND_XBAR     4'h7

// ------------------------------------------------------------
// crossbar select registers (kind XBAR, port field picks one)
// ------------------------------------------------------------
`define PIO_XBAR_FIRST    2'h0
`define PIO_XBAR_SECOND   2'h1
`define PIO_XBAR_THIRD    2'h2
`define PIO_BIT_UART_EN   0
`define PIO_BIT_RADIO_EN  1
`define PIO_BIT_CROSSBAR_GLOBAL_ENABLE     6
`define PIO_BIT_PUD       7

// ------------------------------------------------------------
// pin layout: index 8*port+bit over three byte-wide ports
// ------------------------------------------------------------
`define PIO_PIN_EXIST     24'h80_7fff
`define PIO_PIN_ANALOG    24'h00_7fff
`define PIO_XBAR_LAST     14
`define PIO_UART_TX_PIN   4
`define PIO_UART_RX_PIN   5
`define PIO_RADIO_SCK     8
`define PIO_RADIO_MISO    9
`define PIO_RADIO_MOSI    10
`define PIO_RADIO_NSS     11
`define PIO_DEBUG_PIN     23

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PIO_RST_LATCH     24'hff_ffff
`define PIO_RST_ADSEL     24'hff_ffff
`define PIO_RST_OTYPE     24'h00_0000
`define PIO_RST_DRIVE     24'h00_0000
`define PIO_RST_SKIP      24'h00_0000
`define PIO_RST_MMASK     24'h00_0000
`define PIO_RST_MVAL      24'h00_0000
`define PIO_RST_XBAR      8'h00

`endif

/* File: design/pio_sync.v */
`timescale 1ns/1ps

// ------------------------------------------------------------
// two-stage synchroniser for asynchronous pad levels
// ------------------------------------------------------------
module pio_sync #(
  parameter WIDTH = 24
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // first stage feeds only the second stage
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

/* File: design/pio_top.v */
// Functional notes
// - reset leaves every cell digital, not driving, with its weak pull-up on.
// - select bit 0 makes the cell analog; pull-up and input receiver off.
// - an analog pin always reads back as 0.
// - output-type 1 drives the pad high or low from the output value.
// - open-drain pulls low only for value 0, releases the pad for 1.
// - pull-up on while the cell is high impedance, off while driving low.
// - global pull-up disable at 1 turns all weak pull-ups off.
// - a digital pin reads the sensed pad level, not its latch.
// - per-pin drive strength select, low strength by default.
// - a skipped pin is never claimed by the crossbar.
// - serial port and radio serial port sit on fixed pins.
// - event capture sees digital pin transitions, skipped or assigned.
// - event capture ignores analog pins.
// - pins 1.0 to 1.3 carry the radio serial link.
// - pin 2.7 is general I/O sharing its pad with the debug data line.
// - three byte-wide ports; first fifteen pins selectable digital or analog.
// - all cell output drivers off while the crossbar global enable is 0; the debug data line can still drive pin 2.7.
// - other peripherals take the lowest free unskipped pin in priority order.
`timescale 1ns/1ps
`include "pio_map.vh"

module pio_top #(
  parameter N_GEN = 4
) (
  // clock and reset
  input  wire                   core_clk,
  input  wire                   rst,
  // register port
  input  wire [`PIO_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output wire [7:0]             reg_rdata,
  // pads, index 8*port+bit
  input  wire [23:0]            pad_in,
  output wire [23:0]            pad_out,
  output wire [23:0]            pad_oe,
  output wire [23:0]            pad_pullup_en,
  output wire [23:0]            pad_rx_en,
  output wire [23:0]            pad_drive_high,
  // fixed serial port
  input  wire                   uart_tx,
  output wire                   uart_rx,
  // radio serial port
  input  wire                   radio_sck,
  input  wire                   radio_mosi,
  input  wire                   radio_nss,
  output wire                   radio_miso,
  // priority-assigned peripherals, bit 0 highest
  input  wire [N_GEN-1:0]       gen_out,
  input  wire [N_GEN-1:0]       gen_oe,
  output wire [N_GEN-1:0]       gen_in,
  output wire [N_GEN-1:0]       gen_placed,
  // debug data line on the shared pad
  input  wire                   debug_data_out,
  input  wire                   debug_data_oe,
  output wire                   debug_data_in,
  // event capture
  output wire                   port_match,
  output wire                   pin_edge
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one port's byte of a 24-bit pin mask, cut on purpose to eight bits
  function [7:0] port_bits;
    input [23:0] mask;
    input [1:0]  port;
    reg   [23:0] s;
    begin
      s = mask >> (8*port);
      port_bits = s[7:0];
    end
  endfunction

  function [23:0] merge_byte;
    input [23:0] old;
    input [1:0]  port;
    input [7:0]  data;
    input [23:0] keep_one;
    reg   [23:0] r;
    begin
      r = old;
      r[8*port +: 8] = (data & port_bits(`PIO_PIN_EXIST, port)) | keep_one[8*port +: 8];
      merge_byte = r;
    end
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg  [23:0] latch_r;
  reg  [23:0] adsel_r;
  reg  [23:0] otype_r;
  reg  [23:0] drive_r;
  reg  [23:0] skip_r;
  reg  [23:0] mmask_r;
  reg  [23:0] mval_r;
  reg  [7:0]  xbar_first_r;
  reg  [7:0]  xbar_second_r;
  reg  [7:0]  xbar_third_r;
  reg  [7:0]  rdata_r;
  reg  [7:0]  rdata_nxt;
  reg  [23:0] pin_prev_r;
  reg         port_match_r;
  reg         pin_edge_r;

  wire [3:0]  kind = reg_addr[5:2];
  wire [1:0]  port = reg_addr[1:0];
  wire        port_ok = (port != 2'h3);
  wire [23:0] pad_sync;
  wire        xbar_en   = xbar_third_r[`PIO_BIT_CROSSBAR_GLOBAL_ENABLE];
  wire        pud       = xbar_third_r[`PIO_BIT_PUD];
  wire        uart_en   = xbar_first_r[`PIO_BIT_UART_EN];
  wire        radio_en  = xbar_first_r[`PIO_BIT_RADIO_EN];
  // pins without an analog option stay digital whatever software writes
  wire [23:0] digital   = (adsel_r | ~`PIO_PIN_ANALOG) & `PIO_PIN_EXIST;
  wire [23:0] pin_read  = pad_sync & digital;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      latch_r       <= `PIO_RST_LATCH;
      adsel_r       <= `PIO_RST_ADSEL;
      otype_r       <= `PIO_RST_OTYPE;
      drive_r       <= `PIO_RST_DRIVE;
      skip_r        <= `PIO_RST_SKIP;
      mmask_r       <= `PIO_RST_MMASK;
      mval_r        <= `PIO_RST_MVAL;
      xbar_first_r  <= `PIO_RST_XBAR;
      xbar_second_r <= `PIO_RST_XBAR;
      xbar_third_r  <= `PIO_RST_XBAR;
    end
    else if (reg_wr && port_ok)
    begin
      // one bit per pin outside the crossbar registers, bit n drives pin n of the addressed port
      if (kind == `PIO_KIND_LATCH)
        latch_r <= merge_byte(latch_r, port, reg_wdata, 24'h0);
      else if (kind == `PIO_KIND_ADSEL)
        adsel_r <= merge_byte(adsel_r, port, reg_wdata & port_bits(`PIO_PIN_ANALOG, port), 24'h0);
      else if (kind == `PIO_KIND_OTYPE)
        otype_r <= merge_byte(otype_r, port, reg_wdata, 24'h0);
      else if (kind == `PIO_KIND_DRIVE)
        drive_r <= merge_byte(drive_r, port, reg_wdata, 24'h0);
      else if (kind == `PIO_KIND_SKIP)
        skip_r <= merge_byte(skip_r, port, reg_wdata, 24'h0);
      else if (kind == `PIO_KIND_MMASK)
        mmask_r <= merge_byte(mmask_r, port, reg_wdata, 24'h0);
      else if (kind == `PIO_KIND_MVAL)
        mval_r <= merge_byte(mval_r, port, reg_wdata, 24'h0);
      else if (kind == `PIO_KIND_XBAR)
      begin
        if (port == `PIO_XBAR_FIRST)
          xbar_first_r <= reg_wdata & 8'h03;
        else if (port == `PIO_XBAR_SECOND)
          xbar_second_r <= reg_wdata;
        else
          xbar_third_r <= reg_wdata & 8'hc0;
      end
    end
  end

  // ------------------------------------------------------------
  // read port: data valid only in the cycle after the strobe
  // ------------------------------------------------------------
  always @*
  begin
    rdata_nxt = 8'h00;
    if (reg_rd && port_ok)
    begin
      if (kind == `PIO_KIND_LATCH)
        rdata_nxt = pin_read[8*port +: 8];
      else if (kind == `PIO_KIND_ADSEL)
        rdata_nxt = adsel_r[8*port +: 8] & port_bits(`PIO_PIN_ANALOG, port);
      else if (kind == `PIO_KIND_OTYPE)
        rdata_nxt = otype_r[8*port +: 8];
      else if (kind == `PIO_KIND_DRIVE)
        rdata_nxt = drive_r[8*port +: 8];
      else if (kind == `PIO_KIND_SKIP)
        rdata_nxt = skip_r[8*port +: 8];
      else if (kind == `PIO_KIND_MMASK)
        rdata_nxt = mmask_r[8*port +: 8];
      else if (kind == `PIO_KIND_MVAL)
        rdata_nxt = mval_r[8*port +: 8];
      else if (kind == `PIO_KIND_XBAR)
      begin
        if (port == `PIO_XBAR_FIRST)
          rdata_nxt = xbar_first_r;
        else if (port == `PIO_XBAR_SECOND)
          rdata_nxt = xbar_second_r;
        else
          rdata_nxt = xbar_third_r;
      end
    end
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

  // ------------------------------------------------------------
  // pad input synchroniser
  // ------------------------------------------------------------
  pio_sync #(
    .WIDTH    (24)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  // ------------------------------------------------------------
  // priority crossbar
  // ------------------------------------------------------------
  reg [23:0]      own;
  reg [23:0]      own_val;
  reg [23:0]      own_drv;
  reg [23:0]      taken;
  reg [N_GEN-1:0] placed;
  reg [5*N_GEN-1:0] gen_pin;
  reg             found;
  integer         k;
  integer         i;

  always @*
  begin
    own     = 24'h0;
    own_val = 24'h0;
    own_drv = 24'h0;
    placed  = {N_GEN{1'b0}};
    gen_pin = {5*N_GEN{1'b0}};
    found   = 1'b0;
    // fixed pins first; a skipped pin is still never claimed
    if (uart_en)
    begin
      own[`PIO_UART_TX_PIN]     = ~skip_r[`PIO_UART_TX_PIN];
      own_val[`PIO_UART_TX_PIN] = uart_tx;
      own_drv[`PIO_UART_TX_PIN] = 1'b1;
      own[`PIO_UART_RX_PIN]     = ~skip_r[`PIO_UART_RX_PIN];
    end
    if (radio_en)
    begin
      own[`PIO_RADIO_SCK]      = ~skip_r[`PIO_RADIO_SCK];
      own_val[`PIO_RADIO_SCK]  = radio_sck;
      own_drv[`PIO_RADIO_SCK]  = 1'b1;
      own[`PIO_RADIO_MISO]     = ~skip_r[`PIO_RADIO_MISO];
      own[`PIO_RADIO_MOSI]     = ~skip_r[`PIO_RADIO_MOSI];
      own_val[`PIO_RADIO_MOSI] = radio_mosi;
      own_drv[`PIO_RADIO_MOSI] = 1'b1;
      own[`PIO_RADIO_NSS]      = ~skip_r[`PIO_RADIO_NSS];
      own_val[`PIO_RADIO_NSS]  = radio_nss;
      own_drv[`PIO_RADIO_NSS]  = 1'b1;
    end
    taken = own | skip_r;
    for (k = 0; k < N_GEN; k = k + 1)
    begin
      found = 1'b0;
      if (xbar_second_r[k])
      begin
        for (i = 0; i <= `PIO_XBAR_LAST; i = i + 1)
        begin
          if (!found && !taken[i])
          begin
            found            = 1'b1;
            taken[i]         = 1'b1;
            own[i]           = 1'b1;
            own_val[i]       = gen_out[k];
            own_drv[i]       = gen_oe[k];
            gen_pin[5*k +: 5] = i[4:0];
          end
        end
      end
      placed[k] = found;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_GEN; g = g + 1)
    begin : g_gen_in
      assign gen_in[g] = placed[g] & pin_read[gen_pin[5*g +: 5]];
    end
  endgenerate

  assign gen_placed = placed;
  assign uart_rx    = pin_read[`PIO_UART_RX_PIN];
  assign radio_miso = pin_read[`PIO_RADIO_MISO];

  // ------------------------------------------------------------
  // cell drivers
  // ------------------------------------------------------------
  wire [23:0] out_val  = (own & own_val) | (~own & latch_r);
  // drivers stay off until the crossbar is enabled
  wire [23:0] want_drv = {24{xbar_en}} & (~own | own_drv);
  wire [23:0] pp_oe    = want_drv & otype_r;
  wire [23:0] od_oe    = want_drv & ~otype_r & ~out_val;
  wire [23:0] cell_oe  = (pp_oe | od_oe) & `PIO_PIN_EXIST;
  wire [23:0] cell_out = pp_oe & out_val;
  // debug owns the shared pad while it drives, even with the crossbar off
  wire [23:0] dbg_sel  = {debug_data_oe, 23'h0};

  assign pad_oe         = (cell_oe & ~dbg_sel) | dbg_sel;
  assign pad_out        = (cell_out & ~dbg_sel) | (dbg_sel & {24{debug_data_out}});
  // pull-up only while released; a driven-low pad never sees it
  assign pad_pullup_en  = digital & ~pad_oe & {24{~pud}};
  assign pad_rx_en      = digital;
  assign pad_drive_high = drive_r & `PIO_PIN_EXIST;
  assign debug_data_in  = pad_sync[`PIO_DEBUG_PIN];

  // ------------------------------------------------------------
  // event capture on digital pins only
  // ------------------------------------------------------------
  wire [23:0] watch = mmask_r & digital;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_prev_r   <= 24'h0;
      port_match_r <= 1'b0;
      pin_edge_r   <= 1'b0;
    end
    else
    begin
      // works on skipped and crossbar-assigned pins alike
      pin_prev_r   <= pin_read;
      port_match_r <= |((pin_read ^ mval_r) & watch);
      pin_edge_r   <= |((pin_read ^ pin_prev_r) & watch);
    end
  end

  assign port_match = port_match_r;
  assign pin_edge   = pin_edge_r;

endmodule

/* File: testbench/pio_top_properties.sv */
`timescale 1ns/1ps
`include "pio_map.vh"

module pio_top_properties #(
  parameter N_GEN = 4
) (
  // clock and reset
  input wire                   core_clk,
  input wire                   rst,
  // register port
  input wire [`PIO_ADDR_W-1:0] reg_addr,
  input wire [7:0]             reg_wdata,
  input wire                   reg_wr,
  input wire                   reg_rd,
  input wire [7:0]             reg_rdata,
  // pads and peripherals
  input wire [23:0]            pad_in,
  input wire [23:0]            pad_out,
  input wire [23:0]            pad_oe,
  input wire [23:0]            pad_pullup_en,
  input wire [23:0]            pad_rx_en,
  input wire                   uart_tx,
  input wire                   pin_edge
);
  // shadows of only the control bits the properties lean on
  reg       crossbar_global_enable_r;
  reg       pud_r;
  reg       uart_en_r;
  reg       otype4_r;
  reg [7:0] skip0_r;
  reg [7:0] mask1_r;
  reg [7:0] adsel1_r;

  always @(posedge core_clk or posedge rst)
    if (rst)
    begin
      crossbar_global_enable_r   <= 1'b0;
      pud_r     <= 1'b0;
      uart_en_r <= 1'b0;
      otype4_r  <= 1'b0;
      skip0_r   <= 8'h00;
      mask1_r   <= 8'h00;
      adsel1_r  <= 8'hff;
    end
    else if (reg_wr)
    begin
      if (reg_addr == {`PIO_KIND_XBAR, `PIO_XBAR_THIRD})
      begin
        crossbar_global_enable_r <= reg_wdata[`PIO_BIT_CROSSBAR_GLOBAL_ENABLE];
        pud_r   <= reg_wdata[`PIO_BIT_PUD];
      end
      if (reg_addr == {`PIO_KIND_XBAR, `PIO_XBAR_FIRST})
        uart_en_r <= reg_wdata[`PIO_BIT_UART_EN];
      if (reg_addr == {`PIO_KIND_OTYPE, 2'h0})
        otype4_r <= reg_wdata[4];
      if (reg_addr == {`PIO_KIND_SKIP, 2'h0})
        skip0_r <= reg_wdata;
      if (reg_addr == {`PIO_KIND_MMASK, 2'h1})
        mask1_r <= reg_wdata;
      if (reg_addr == {`PIO_KIND_ADSEL, 2'h1})
        adsel1_r <= reg_wdata;
    end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reset_default: assert property ($fell(rst) |-> pad_pullup_en == `PIO_PIN_EXIST && pad_oe[22:0] == 23'h0
    && pad_rx_en == `PIO_PIN_EXIST) else $error("cells not in default state after reset");
  a_analog_pull_off: assert property (((pad_pullup_en[15:8] | pad_rx_en[15:8]) & ~adsel1_r & 8'h7f) == 8'h00)
    else $error("pull-up left on with receiver off");
  a_analog_reads_zero: assert property (reg_rd && reg_addr == {`PIO_KIND_LATCH, 2'h1}
    |=> (reg_rdata & ~$past(adsel1_r)) == 8'h00) else $error("analog pin read back nonzero");
  a_oe_pull_excl: assert property ((pad_oe & pad_pullup_en) == 24'h0)
    else $error("pull-up on while pad driven");
  a_pud_all_off: assert property (pud_r |-> pad_pullup_en == 24'h0)
    else $error("pull-up on under global disable");
  a_xbar_off_quiet: assert property (!crossbar_global_enable_r |-> pad_oe[22:0] == 23'h0)
    else $error("pad driven with crossbar off");
  a_uart_fixed: assert property (crossbar_global_enable_r && uart_en_r && !skip0_r[4] |-> pad_oe[4] == (otype4_r | !uart_tx)
    && pad_out[4] == (otype4_r & uart_tx)) else $error("serial transmit not on its fixed pin");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_edge_follows: assert property (((pad_in[15:8] ^ $past(pad_in[15:8])) & mask1_r & adsel1_r) != 8'h00
    |-> ##[1:4] pin_edge) else $error("watched pin change gave no event");

  c_edge: cover property (pin_edge);
  c_pud: cover property (pud_r && crossbar_global_enable_r);
  c_uart: cover property (crossbar_global_enable_r && uart_en_r && !skip0_r[4]);
endmodule

bind pio_top pio_top_properties #(.N_GEN(N_GEN)) pio_top_properties_i (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
  .pad_pullup_en(pad_pullup_en), .pad_rx_en(pad_rx_en), .uart_tx(uart_tx), .pin_edge(pin_edge));

/* File: testbench/pio_pad_model.sv */
`timescale 1ns/1ps

module pio_pad_model (
  // clock
  input  wire        core_clk,
  // cell side
  input  wire [23:0] pad_out,
  input  wire [23:0] pad_oe,
  input  wire [23:0] pad_pullup_en,
  // outside circuits
  input  wire [23:0] ext_en,
  input  wire [23:0] ext_val,
  output wire [23:0] pad_level
);
  // an unheld pad flips every cycle so a floating read never looks settled
  reg [23:0] float_r = 24'h00_0000;

  always @(posedge core_clk)
    float_r <= ~float_r;

  // the cell's own driver wins a fight with an outside driver
  assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                   | (~pad_oe & ~ext_en & (pad_pullup_en | float_r));
endmodule

/* File: testbench/pio_top_test.sv */
`timescale 1ns/1ps
`include "pio_map.vh"

module pio_top_test;
  reg                    core_clk;
  reg                    rst;
  reg  [`PIO_ADDR_W-1:0] reg_addr;
  reg  [7:0]             reg_wdata;
  reg                    reg_wr;
  reg                    reg_rd;
  wire [7:0]             reg_rdata;
  wire [23:0]            pad_in;
  wire [23:0]            pad_out;
  wire [23:0]            pad_oe;
  wire [23:0]            pad_pullup_en;
  wire [23:0]            pad_rx_en;
  wire [23:0]            pad_drive_high;
  reg                    uart_tx;
  wire                   uart_rx;
  reg                    radio_sck;
  reg                    radio_mosi;
  reg                    radio_nss;
  wire                   radio_miso;
  reg  [3:0]             gen_out;
  reg  [3:0]             gen_oe;
  wire [3:0]             gen_in;
  wire [3:0]             gen_placed;
  reg                    debug_data_out;
  reg                    debug_data_oe;
  wire                   debug_data_in;
  wire                   port_match;
  wire                   pin_edge;
  reg  [23:0]            ext_en;
  reg  [23:0]            ext_val;
  integer                fails;
  integer                check_count;
  integer                edges;
  integer                i;

  pio_top #(.N_GEN(4)) pio_top_i (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .pad_rx_en(pad_rx_en), .pad_drive_high(pad_drive_high),
    .uart_tx(uart_tx), .uart_rx(uart_rx), .radio_sck(radio_sck), .radio_mosi(radio_mosi),
    .radio_nss(radio_nss), .radio_miso(radio_miso), .gen_out(gen_out), .gen_oe(gen_oe),
    .gen_in(gen_in), .gen_placed(gen_placed), .debug_data_out(debug_data_out),
    .debug_data_oe(debug_data_oe), .debug_data_in(debug_data_in), .port_match(port_match),
    .pin_edge(pin_edge));

  pio_pad_model pio_pad_model_i (
    .core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_in));

  // ----------
  // bus tasks and comparisons
  // ----------
  task end_sim;
    begin
      if (fails == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task chk_reg(input string nm, input [7:0] exp, input [7:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task chk_pad(input string nm, input [23:0] exp, input [23:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // a gap cycle after each strobe keeps one assignment per signal per edge
  task wr(input [3:0] k, input [1:0] p, input [7:0] d);
    begin
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= {k, p};
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask

  task rd_chk(input string nm, input [3:0] k, input [1:0] p, input [7:0] exp);
    begin
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= {k, p};
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk_reg(nm, exp, reg_rdata);
    end
  endtask

  always @(posedge core_clk)
    if (pin_edge === 1'b1)
      edges = edges + 1;

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // whole sequence needs well under a thousand cycles
  initial
  begin
    #20000;
    fails = fails + 1;
    end_sim;
  end

  // ----------
  // scenarios
  // ----------
  initial
  begin
    {fails, check_count, edges} = 0;
    {rst, radio_nss} = 2'b11;
    {reg_addr, reg_wdata, reg_wr, reg_rd, uart_tx, radio_sck, radio_mosi} = 0;
    {gen_out, gen_oe, debug_data_out, debug_data_oe} = 0;
    ext_en = 24'h00_7f00;
    ext_val = 24'h00_5500;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk_pad("oe", 24'h0, pad_oe);
    chk_pad("pullup", `PIO_PIN_EXIST, pad_pullup_en);
    chk_pad("rx", `PIO_PIN_EXIST, pad_rx_en);
    chk_pad("drive", 24'h0, pad_drive_high);
    rd_chk("adsel0", `PIO_KIND_ADSEL, 2'h0, 8'hff);
    rd_chk("unmapped", `PIO_KIND_LATCH, 2'h3, 8'h00);
    wr(`PIO_KIND_OTYPE, 2'h0, 8'h0f);
    wr(`PIO_KIND_LATCH, 2'h0, 8'h05);
    chk_pad("oe xbar off", 24'h0, pad_oe);
    wr(`PIO_KIND_XBAR, `PIO_XBAR_THIRD, 8'h40);
    chk_pad("oe", 24'h00_00ff, pad_oe);
    chk_pad("out", 24'h00_0005, pad_out & pad_oe);
    chk_pad("pullup", 24'h80_7f00, pad_pullup_en);
    wr(`PIO_KIND_LATCH, 2'h0, 8'haf);
    chk_pad("oe od", 24'h00_005f, pad_oe);
    chk_pad("out od", 24'h00_000f, pad_out & pad_oe);
    wr(`PIO_KIND_DRIVE, 2'h1, 8'hff);
    rd_chk("drive1", `PIO_KIND_DRIVE, 2'h1, 8'h7f);
    chk_pad("drive", 24'h00_7f00, pad_drive_high);
    wr(`PIO_KIND_XBAR, `PIO_XBAR_THIRD, 8'hc0);
    chk_pad("pud", 24'h0, pad_pullup_en);
    wr(`PIO_KIND_XBAR, `PIO_XBAR_THIRD, 8'h40);
    rd_chk("pad1", `PIO_KIND_LATCH, 2'h1, 8'h55);
    wr(`PIO_KIND_SKIP, 2'h1, 8'h0f);
    wr(`PIO_KIND_ADSEL, 2'h1, 8'hf0);
    chk_pad("rx analog", 24'h80_70ff, pad_rx_en);
    chk_pad("pull analog", 24'h80_70a0, pad_pullup_en);
    rd_chk("analog rd", `PIO_KIND_LATCH, 2'h1, 8'h50);
    wr(`PIO_KIND_MVAL, 2'h1, 8'h10);
    wr(`PIO_KIND_MMASK, 2'h1, 8'h10);
    repeat (4) @(posedge core_clk);
    #1 edges = 0;
    ext_val[12] <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    chk_reg("edges", 8'h01, edges[7:0]);
    chk_reg("match", 8'h01, {7'h0, port_match});
    wr(`PIO_KIND_MMASK, 2'h1, 8'h01);
    repeat (4) @(posedge core_clk);
    #1 edges = 0;
    ext_val[8] <= 1'b0;
    repeat (2) @(posedge core_clk);
    ext_val[8] <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    chk_reg("analog edges", 8'h00, edges[7:0]);
    chk_reg("analog match", 8'h00, {7'h0, port_match});
    wr(`PIO_KIND_ADSEL, 2'h1, 8'hff);
    wr(`PIO_KIND_SKIP, 2'h1, 8'h00);
    ext_val[9] <= 1'b1;
    wr(`PIO_KIND_OTYPE, 2'h0, 8'h1f);
    wr(`PIO_KIND_OTYPE, 2'h1, 8'h0d);
    wr(`PIO_KIND_XBAR, `PIO_XBAR_FIRST, 8'h03);
    for (i = 0; i < 2; i = i + 1)
    begin
      @(posedge core_clk);
      uart_tx    <= i[0];
      radio_sck  <= i[0];
      radio_mosi <= ~i[0];
      @(posedge core_clk);
      #1;
      chk_reg("uart pin", {6'h0, 1'b1, i[0]}, {6'h0, pad_oe[4], pad_out[4]});
      chk_reg("radio", {4'h0, 1'b1, ~i[0], i[0], 1'b1}, {4'h0, pad_out[11:10], pad_out[8], pad_oe[8]});
    end
    chk_reg("miso", 8'h01, {7'h0, radio_miso});
    chk_reg("uart rx", 8'h01, {7'h0, uart_rx});
    wr(`PIO_KIND_SKIP, 2'h0, 8'h30);
    chk_reg("skipped uart", 8'h02, {6'h0, pad_oe[4], pad_out[4]});
    wr(`PIO_KIND_SKIP, 2'h0, 8'h03);
    @(posedge core_clk);
    gen_oe  <= 4'h3;
    gen_out <= 4'h2;
    wr(`PIO_KIND_XBAR, `PIO_XBAR_SECOND, 8'h03);
    chk_reg("gen", 8'h0e, {2'h0, gen_placed, pad_out[3:2]});
    repeat (2) @(posedge core_clk);
    #1;
    chk_reg("gen in", 8'h02, {4'h0, gen_in});
    wr(`PIO_KIND_SKIP, 2'h0, 8'hff);
    wr(`PIO_KIND_SKIP, 2'h1, 8'hff);
    chk_reg("gen none", 8'h00, {4'h0, gen_placed});
    @(posedge core_clk);
    debug_data_oe <= 1'b1;
    @(posedge core_clk);
    #1;
    chk_reg("debug pad", 8'h02, {6'h0, pad_oe[23], pad_out[23]});
    @(posedge core_clk);
    debug_data_oe <= 1'b0;
    wr(`PIO_KIND_LATCH, 2'h2, 8'h00);
    chk_reg("gpio pad", 8'h02, {6'h0, pad_oe[23], pad_out[23]});
    repeat (2) @(posedge core_clk);
    #1;
    chk_reg("debug in", 8'h00, {7'h0, debug_data_in});
    end_sim;
  end
endmodule
